// [bench/dmc_mode_regs_bench.sv]
// self-checking bench for the converter mode control register bank
`timescale 1ns/1ps
`default_nettype none

module dmc_mode_regs_bench;
  import dmc_pkg::*;
  typedef struct {string nm; logic [7:0] v;} dmc_note_s;
  logic core_clk_in, reset_n_in, clk_en_in, pll_lock_in, csb_in, sclk_in, sdio_in;
  logic sdio_out, sdio_oe_out, sdo_out, sdo_oe_out, done, pin_v, power_down_out;
  logic reference_resistor_count_one_out, unsigned_data_out, q_first_out;
  logic offset_current_on_complement_out;
  logic [3:0]  interp_factor_out;
  logic [7:0]  rdata, pin_val, v;
  logic [31:0] seed;     // xorshift state
  int          err_total, tests_run;
  dmc_note_s   note_q[$];  // expectations in order of arrival

  dmc_mode_regs u_dut (
    .core_clk_in, .reset_n_in, .clk_en_in, .csb_in, .sclk_in, .sdio_in, .sdio_out,
    .sdio_oe_out, .sdo_out, .sdo_oe_out, .pll_lock_in, .sleep_out(), .power_down_out,
    .reference_resistor_count_one_out, .chip_restart_out(), .interp_rate_out(),
    .interp_factor_out, .modulation_out(), .zero_stuff_out(), .real_mix_out(),
    .plus_sideband_out(), .data_rate_clock_on_lock_pin_out(), .unsigned_data_out,
    .single_port_mode_out(), .data_rate_clock_strong_out(), .data_rate_clock_invert_out(),
    .single_port_clock_invert_out(), .channel_select_input_invert_out(), .q_first_out,
    .data_rate_clock_on_sdo_out(), .prescaler_out(), .pll_enable_out(),
    .charge_pump_manual_out(), .charge_pump_ctrl_out(), .in_phase_fine_gain_out(),
    .in_phase_coarse_gain_out(), .in_phase_offset_out(), .offset_current_on_complement_out,
    .quadrature_fine_gain_out());

  dmc_spi_host u_host (.core_clk_in, .csb_out(csb_in), .sclk_out(sclk_in),
    .sdio_wire_out(sdio_in), .dev_sdio_in(sdio_out), .dev_oe_in(sdio_oe_out),
    .dev_sdo_in(sdo_out), .done_out(done), .rdata_out(rdata));

  // --------------------
  // helpers
  // --------------------
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  // writable bits of registers 01h..09h, the rest read zero
  function automatic logic [7:0] msk(input int a);
    case (a)
      2: return WMASK_FORMAT;
      3: return WMASK_RATE_CLK;
      4: return WMASK_LOOP;
      6: return WMASK_I_COARSE;
      8: return WMASK_I_OFS_LO;
      default: return 8'hFF;
    endcase
  endfunction : msk

  task automatic wr(input int a, input logic [7:0] d);
    u_host.xfer(1'b0, 5'(a), d);
  endtask : wr

  task automatic rd(input int a, input logic [7:0] e);
    note_q.push_back('{$sformatf("register %0h", a), e});
    u_host.xfer(1'b1, 5'(a), 8'h00);
  endtask : rd

  task automatic pin(input string nm, input logic [7:0] e, input logic [7:0] s);
    note_q.push_back('{nm, e});
    @(negedge core_clk_in) pin_v = 1'b1;
    pin_val = s;
    @(negedge core_clk_in) pin_v = 1'b0;
  endtask : pin

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // --------------------
  // clock, watchdog and result monitor
  // --------------------
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  // a hang counts as a mismatch
  initial begin
    repeat (60000) @(posedge core_clk_in);
    err_total++;
    wrap_up();
  end

  // oldest note is compared against each result as it appears
  always @(posedge core_clk_in) begin
    if (done || pin_v) begin
      tests_run++;
      if ((done ? rdata : pin_val) !== note_q[0].v) begin
        err_total++;
        $display("CHECK FAILED %s expected %h seen %h", note_q[0].nm, note_q[0].v, done ? rdata : pin_val);
      end
      void'(note_q.pop_front());
    end
  end

  // --------------------
  // main sequence
  // --------------------
  initial begin
    reset_n_in = 1'b0;
    clk_en_in = 1'b1;
    pll_lock_in = 1'b0;
    pin_v = 1'b0;
    pin_val = 8'h00;
    seed = 32'h0000B69B;
    err_total = 0;
    tests_run = 0;
    repeat (2) @(negedge core_clk_in);
    reset_n_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    for (int a = 0; a < 10; a++) rd(a, (a == 1) ? 8'h04 : 8'h00);
    $display("reset values done");
    // random data, unassigned bits must read zero
    for (int a = 1; a < 10; a++) begin
      v = rnd();
      wr(a, v);
      rd(a, v & msk(a));
    end
    wr(8'h0A, 8'hFF);
    rd(8'h0A, 8'h00);
    rd(8'h1F, 8'h00);
    $display("readback and unmapped done");
    for (int c = 0; c < 4; c++) begin
      wr(1, {2'(c), 6'h04});
      pin("interp factor", 8'(4'h1 << c), 8'(interp_factor_out));
    end
    for (int b = 0; b < 2; b++) begin
      wr(2, {b[0], 6'h00, b[0]});
      pin("unsigned data", 8'(b), 8'(unsigned_data_out));
      pin("q first", 8'(b), 8'(q_first_out));
      wr(8, {b[0], 7'h00});
      pin("offset on complement", 8'(b), 8'(offset_current_on_complement_out));
      wr(0, {5'h00, b[0], 2'h0});
      pin("one resistor", 8'(b), 8'(reference_resistor_count_one_out));
    end
    $display("setting pins done");
    // lock shows only while the multiplier is on
    wr(4, 8'h00);
    pll_lock_in = 1'b1;
    rd(0, 8'h04);
    wr(4, 8'h80);
    rd(0, 8'h06);
    pll_lock_in = 1'b0;
    rd(0, 8'h04);
    $display("lock status done");
    // serial port keeps working in power-down, slow host
    u_host.hold = 8;
    wr(0, 8'h08);
    pin("power down", 8'h01, 8'(power_down_out));
    wr(5, 8'h5A);
    rd(5, 8'h5A);
    clk_en_in = 1'b0;
    repeat (5) @(negedge core_clk_in);
    clk_en_in = 1'b1;
    wr(0, 8'h24);
    rd(0, 8'h04);
    rd(1, 8'h04);
    rd(5, 8'h00);
    pin("power down", 8'h00, 8'(power_down_out));
    $display("power down and soft reset done");
    // lsb first on the shared pin, fastest host
    u_host.hold = 2;
    wr(0, 8'hC0);
    u_host.lsb_mode = 1'b1;
    u_host.bidir_mode = 1'b1;
    v = rnd();
    wr(7, v);
    rd(7, v);
    rd(0, 8'hC0);
    wr(0, 8'h00);
    u_host.lsb_mode = 1'b0;
    u_host.bidir_mode = 1'b0;
    rd(7, v);
    $display("bit order and shared pin done");
    // a pin reset clears address 00h as well
    wr(0, 8'h04);
    reset_n_in = 1'b0;
    repeat (2) @(negedge core_clk_in);
    reset_n_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    rd(0, 8'h00);
    rd(7, 8'h00);
    $display("second reset done");
    wrap_up();
  end
endmodule : dmc_mode_regs_bench

`default_nettype wire

// [bench/dmc_mode_regs_sva.sv]
// port-level assertions for the converter mode control register bank
`timescale 1ns/1ps
`default_nettype none

module dmc_regs_chk (
  // clock, reset, enable
  input wire logic       core_clk_in,
  input wire logic       reset_n_in,
  input wire logic       clk_en_in,
  // serial pins
  input wire logic       csb_in,
  input wire logic       sclk_in,
  input wire logic       sdio_out,
  input wire logic       sdio_oe_out,
  input wire logic       sdo_out,
  input wire logic       sdo_oe_out,
  // watched settings; the rate code is seen as its plain two bits
  input wire logic       chip_restart_out,
  input wire logic       power_down_out,
  input wire logic       real_mix_out,
  input wire logic [1:0] interp_rate_out,
  input wire logic [3:0] interp_factor_out,
  input wire logic [7:0] in_phase_fine_gain_out
);
  import dmc_pkg::*;

  // --------------------
  // one clock domain, so one default clock and disable
  // --------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  restart_pulse_a: assert property (chip_restart_out |=> !chip_restart_out)
    else $error("restart pulse wider than one cycle");
  restart_clear_a: assert property (chip_restart_out |-> ##[0:2] (real_mix_out && interp_factor_out == 4'h1 && in_phase_fine_gain_out == 8'h00))
    else $error("software reset left settings changed");
  rate_factor_a: assert property ($stable(interp_rate_out) |-> interp_factor_out == (4'h1 << interp_rate_out))
    else $error("interpolation factor does not match its code");
  reset_value_a: assert property ($rose(reset_n_in) |-> real_mix_out && interp_factor_out == 4'h1 && !power_down_out)
    else $error("wrong settings after reset");
  oe_drop_a: assert property (csb_in [*3] |-> !sdio_oe_out && !sdo_oe_out)
    else $error("read enable stays up while deselected");
  oe_excl_a: assert property (!(sdio_oe_out && sdo_oe_out))
    else $error("both read pins enabled");
  rd_hold_a: assert property (sdio_oe_out && sclk_in && $past(sclk_in) |-> $stable(sdio_out))
    else $error("read bit moved while serial clock high");
  sdo_hold_a: assert property (sdo_oe_out && sclk_in && $past(sclk_in) |-> $stable(sdo_out))
    else $error("separate read bit moved while serial clock high");
  cfg_idle_a: assert property (csb_in [*8] |-> $stable({power_down_out, real_mix_out, interp_rate_out, in_phase_fine_gain_out}))
    else $error("setting changed with no transfer");
  freeze_a: assert property (!clk_en_in |=> $stable({sdio_oe_out, sdo_oe_out, power_down_out, interp_factor_out}))
    else $error("state moved while clock enable low");

  // main scenarios reached
  cover property (chip_restart_out);
  cover property (sdio_oe_out);
  cover property (power_down_out && sdo_oe_out);
endmodule : dmc_regs_chk

bind dmc_mode_regs dmc_regs_chk u_chk (.*);

`default_nettype wire

// [bench/dmc_spi_host.sv]
// serial port host model that configures the converter register bank
`timescale 1ns/1ps
`default_nettype none

module dmc_spi_host (
  // clock
  input  wire logic       core_clk_in,
  // pins toward the device
  output logic            csb_out,
  output logic            sclk_out,
  output logic            sdio_wire_out,
  input  wire logic       dev_sdio_in,
  input  wire logic       dev_oe_in,
  input  wire logic       dev_sdo_in,
  // readback handed to the bench
  output logic            done_out,
  output logic [7:0]      rdata_out
);
  logic lsb_mode;    // bit order the device was set to
  logic bidir_mode;  // read data comes back on the shared data pin
  logic host_drv;    // level the host puts on the data pin
  int   hold;        // core cycles per serial clock phase, 2 is the fastest legal

  // shared pin: the device wins while its enable is high
  assign sdio_wire_out = dev_oe_in ? dev_sdio_in : host_drv;

  initial begin
    csb_out = 1'b1;
    sclk_out = 1'b0;
    host_drv = 1'b0;
    done_out = 1'b0;
    rdata_out = 8'h00;
    lsb_mode = 1'b0;
    bidir_mode = 1'b0;
    hold = 3;
  end

  // --------------------
  // one single-byte transfer, pins change just after falling edges
  // --------------------
  task automatic xfer(input logic rd, input logic [4:0] addr, input logic [7:0] wdata);
    logic [7:0] ins;
    int         k;
    ins = {rd, 2'b00, addr};
    @(negedge core_clk_in) csb_out = 1'b0;
    for (int i = 0; i < 16; i++) begin
      // same bit order for instruction and data
      k = lsb_mode ? i % 8 : 7 - i % 8;
      @(negedge core_clk_in) sclk_out = 1'b0;
      // a released pin gets a changing level, never the stale bit
      host_drv = (i < 8) ? ins[k] : (rd ? ~host_drv : wdata[k]);
      repeat (hold) @(negedge core_clk_in);
      sclk_out = 1'b1;
      if (i >= 8 && rd) rdata_out[k] = bidir_mode ? sdio_wire_out : dev_sdo_in;
      repeat (hold) @(negedge core_clk_in);
    end
    // leave time for the write to land before deselecting
    repeat (5) @(negedge core_clk_in);
    csb_out = 1'b1;
    sclk_out = 1'b0;
    host_drv = ~host_drv;
    @(negedge core_clk_in) done_out = rd;
    @(negedge core_clk_in) done_out = 1'b0;
    repeat (2) @(negedge core_clk_in);
  endtask : xfer
endmodule : dmc_spi_host

`default_nettype wire

// [hw/dmc_cfg_if.sv]
// carrier between the serial port engine and the register bank
`timescale 1ns/1ps
`default_nettype none

interface dmc_cfg_if;
  logic       wr_stb;      // one-cycle write of wr_data at wr_addr
  logic [4:0] wr_addr;     // write address
  logic [7:0] wr_data;     // write data
  logic [4:0] rd_addr;     // address being read
  logic [7:0] rd_data;     // read value at rd_addr
  logic       lsb_first;   // serial bit order
  logic       sdio_bidir;  // read data leaves on the data-in pin

  modport port (output wr_stb, wr_addr, wr_data, rd_addr,
                input  rd_data, lsb_first, sdio_bidir);
  modport regs (input  wr_stb, wr_addr, wr_data, rd_addr,
                output rd_data, lsb_first, sdio_bidir);
endinterface : dmc_cfg_if

`default_nettype wire

// [hw/dmc_mode_regs.sv]
// mode control register bank of a dual interpolating converter
//
// Notes on behaviour
// - host reaches registers 00h..09h over serial port
// - 01h top bits select the interpolation rate
// - 00h resistor bit: 1 one resistor, 0 two
// - 08h bit7 steers offset current to complement
// - 02h bit7 1 means straight binary input
// - 02h bit0 picks I-then-Q or Q-then-I pairing
// - software reset restores 01h..09h, reads back zero
// - rate codes 00 bypass, 01 x2, 10 x4, 11 x8
// - lock bit shows loop lock while multiplier enabled
// - power-down halts core, serial port keeps working
`timescale 1ns/1ps
`default_nettype none

module dmc_mode_regs (
  // clock, reset, enable
  input  wire logic core_clk_in,
  input  wire logic reset_n_in,
  input  wire logic clk_en_in,
  // serial port pins
  input  wire logic csb_in,
  input  wire logic sclk_in,
  input  wire logic sdio_in,
  output logic      sdio_out,
  output logic      sdio_oe_out,
  output logic      sdo_out,
  output logic      sdo_oe_out,
  // status from the analog side
  input  wire logic pll_lock_in,
  // port and power control
  output logic      sleep_out,
  output logic      power_down_out,
  output logic      reference_resistor_count_one_out,
  output logic      chip_restart_out,
  // interpolation and modulation
  output dmc_pkg::dmc_interp_e interp_rate_out,
  output logic [3:0] interp_factor_out,
  output logic [1:0] modulation_out,
  output logic      zero_stuff_out,
  output logic      real_mix_out,
  output logic      plus_sideband_out,
  output logic      data_rate_clock_on_lock_pin_out,
  // input data format
  output logic      unsigned_data_out,
  output logic      single_port_mode_out,
  output logic      data_rate_clock_strong_out,
  output logic      data_rate_clock_invert_out,
  output logic      single_port_clock_invert_out,
  output logic      channel_select_input_invert_out,
  output logic      q_first_out,
  // clocking and multiplier loop
  output logic      data_rate_clock_on_sdo_out,
  output logic [1:0] prescaler_out,
  output logic      pll_enable_out,
  output logic      charge_pump_manual_out,
  output logic [2:0] charge_pump_ctrl_out,
  // channel trims
  output logic [7:0] in_phase_fine_gain_out,
  output logic [3:0] in_phase_coarse_gain_out,
  output logic [9:0] in_phase_offset_out,
  output logic      offset_current_on_complement_out,
  output logic [7:0] quadrature_fine_gain_out
);
  import dmc_pkg::*;

  // --------------------
  // state
  // --------------------

  // every register of the bank plus derived flops
  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] regs;     // stored values, masked
    logic                     restart;  // software reset pulse
    logic [3:0]               factor;   // decoded rate factor
    logic                     lock;     // qualified lock status
  } dmc_regs_s;

  dmc_regs_s s_q;  // registered state
  dmc_regs_s s_d;  // next state

  dmc_cfg_if cfg ();  // link to the serial engine

  logic [1:0] rate_code;  // rate field of the next value

  // --------------------
  // serial engine
  // --------------------

  // the engine keeps running while power-down is set, so the host
  // can always clear the bit again
  dmc_spi_port u_port (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .clk_en_in   (clk_en_in),
    .csb_in      (csb_in),
    .sclk_in     (sclk_in),
    .sdio_in     (sdio_in),
    .sdio_out    (sdio_out),
    .sdio_oe_out (sdio_oe_out),
    .sdo_out     (sdo_out),
    .sdo_oe_out  (sdo_oe_out),
    .cfg         (cfg.port)
  );

  // --------------------
  // next state
  // --------------------

  // write decode, software reset and derived values
  always_comb begin
    s_d         = s_q;
    s_d.restart = 1'b0;
    if (cfg.wr_stb && cfg.wr_addr < 5'(NUM_REGS)) begin
      // reserved and read-only bits are masked off on the way in
      s_d.regs[cfg.wr_addr] = cfg.wr_data & dmc_wmask(cfg.wr_addr);
      if (cfg.wr_addr == ADDR_PORT_PWR && cfg.wr_data[BIT_SW_RESET]) begin
        // soft reset spares 00h so the port setup survives it
        for (int i = 1; i < NUM_REGS; i++) begin
          s_d.regs[i] = dmc_rst_val(5'(i));
        end
        s_d.restart = 1'b1;
      end
    end
    // decoded rate factor follows the stored code
    rate_code = s_d.regs[ADDR_INTERP][BIT_INTERP_LO+:2];
    case (rate_code)
      INTERP_BYPASS: s_d.factor = 4'h1;
      INTERP_X2:     s_d.factor = 4'h2;
      INTERP_X4:     s_d.factor = 4'h4;
      INTERP_X8:     s_d.factor = 4'h8;
      default:       s_d.factor = 4'h1;
    endcase
    // lock only means something while the multiplier runs
    s_d.lock = pll_lock_in & s_d.regs[ADDR_LOOP][BIT_PLL_ON];
  end

  // state register; clock enable freezes everything
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        s_q.regs[i] <= dmc_rst_val(5'(i));
      end
      s_q.restart <= 1'b0;
      s_q.factor  <= 4'h1;
      s_q.lock    <= 1'b0;
    end else if (clk_en_in) begin
      s_q <= s_d;
    end
  end

  // --------------------
  // readback
  // --------------------

  // the reset bit is never stored, so it always reads zero; the lock
  // bit is inserted live and lags the pin by one cycle
  always_comb begin
    cfg.rd_data = 8'h00;
    if (cfg.rd_addr < 5'(NUM_REGS)) begin
      cfg.rd_data = s_q.regs[cfg.rd_addr];
      if (cfg.rd_addr == ADDR_PORT_PWR) begin
        cfg.rd_data[BIT_LOCK] = s_q.lock;
      end
    end
  end

  // port setup used by the engine
  assign cfg.lsb_first  = s_q.regs[ADDR_PORT_PWR][BIT_LSB_FIRST];
  assign cfg.sdio_bidir = s_q.regs[ADDR_PORT_PWR][BIT_SDIO_BIDIR];

  // --------------------
  // outputs, all straight from flops
  // --------------------

  // port and power control
  assign sleep_out                        = s_q.regs[ADDR_PORT_PWR][BIT_SLEEP];
  assign power_down_out                   = s_q.regs[ADDR_PORT_PWR][BIT_PWR_DOWN];
  assign reference_resistor_count_one_out = s_q.regs[ADDR_PORT_PWR][BIT_ONE_RES];
  assign chip_restart_out                 = s_q.restart;

  // interpolation and modulation
  assign interp_rate_out   = dmc_interp_e'(s_q.regs[ADDR_INTERP][BIT_INTERP_LO+:2]);
  assign interp_factor_out = s_q.factor;
  assign modulation_out    = s_q.regs[ADDR_INTERP][BIT_MOD_LO+:2];
  assign zero_stuff_out    = s_q.regs[ADDR_INTERP][BIT_ZERO_STUFF];
  assign real_mix_out      = s_q.regs[ADDR_INTERP][BIT_REAL_MIX];
  assign plus_sideband_out = s_q.regs[ADDR_INTERP][BIT_PLUS_SIDE];
  assign data_rate_clock_on_lock_pin_out = s_q.regs[ADDR_INTERP][BIT_CLK_ON_PIN];

  // input data format
  assign unsigned_data_out               = s_q.regs[ADDR_FORMAT][BIT_UNSIGNED];
  assign single_port_mode_out            = s_q.regs[ADDR_FORMAT][BIT_ONE_PORT];
  assign data_rate_clock_strong_out      = s_q.regs[ADDR_FORMAT][BIT_CLK_STRONG];
  assign data_rate_clock_invert_out      = s_q.regs[ADDR_FORMAT][BIT_CLK_INVERT];
  assign single_port_clock_invert_out    = s_q.regs[ADDR_FORMAT][BIT_SPC_INVERT];
  assign channel_select_input_invert_out = s_q.regs[ADDR_FORMAT][BIT_SEL_INVERT];
  assign q_first_out                     = s_q.regs[ADDR_FORMAT][BIT_Q_FIRST];

  // clocking and multiplier loop
  assign data_rate_clock_on_sdo_out = s_q.regs[ADDR_RATE_CLK][BIT_CLK_ON_SDO];
  assign prescaler_out              = s_q.regs[ADDR_RATE_CLK][1:0];
  assign pll_enable_out             = s_q.regs[ADDR_LOOP][BIT_PLL_ON];
  assign charge_pump_manual_out     = s_q.regs[ADDR_LOOP][BIT_CP_MANUAL];
  assign charge_pump_ctrl_out       = s_q.regs[ADDR_LOOP][2:0];

  // channel trims; the offset is split high/low across two registers
  assign in_phase_fine_gain_out   = s_q.regs[ADDR_I_FINE];
  assign in_phase_coarse_gain_out = s_q.regs[ADDR_I_COARSE][3:0];
  assign in_phase_offset_out      = {s_q.regs[ADDR_I_OFS_HI], s_q.regs[ADDR_I_OFS_LO][1:0]};
  assign offset_current_on_complement_out = s_q.regs[ADDR_I_OFS_LO][BIT_OFS_DIR];
  assign quadrature_fine_gain_out = s_q.regs[ADDR_Q_FINE];

endmodule : dmc_mode_regs

`default_nettype wire

// [hw/dmc_pkg.sv]
// shared constants and types for the converter mode control register bank
`default_nettype none

package dmc_pkg;

  // --------------------
  // register offsets
  // --------------------
  localparam logic [4:0] ADDR_PORT_PWR  = 5'h00;  // port and power control
  localparam logic [4:0] ADDR_INTERP    = 5'h01;  // interpolation and modulation
  localparam logic [4:0] ADDR_FORMAT    = 5'h02;  // input data format
  localparam logic [4:0] ADDR_RATE_CLK  = 5'h03;  // rate clock and prescaler
  localparam logic [4:0] ADDR_LOOP      = 5'h04;  // multiplier loop control
  localparam logic [4:0] ADDR_I_FINE    = 5'h05;  // i channel fine gain
  localparam logic [4:0] ADDR_I_COARSE  = 5'h06;  // i channel coarse gain
  localparam logic [4:0] ADDR_I_OFS_HI  = 5'h07;  // i offset bits 9..2
  localparam logic [4:0] ADDR_I_OFS_LO  = 5'h08;  // i offset bits 1..0 and direction
  localparam logic [4:0] ADDR_Q_FINE    = 5'h09;  // q channel fine gain
  localparam int         NUM_REGS       = 10;     // registers in this bank

  // --------------------
  // values after reset
  // --------------------
  localparam logic [7:0] RST_DEFAULT    = 8'h00;  // every register but one
  localparam logic [7:0] RST_INTERP     = 8'h04;  // real mix mode is the default

  // --------------------
  // writable bits; all others ignore writes and read zero, except the 00h lock bit, which reads live
  // --------------------
  localparam logic [7:0] WMASK_PORT_PWR = 8'hDC;  // reset bit acts, never stored
  localparam logic [7:0] WMASK_FORMAT   = 8'hF7;
  localparam logic [7:0] WMASK_RATE_CLK = 8'h83;
  localparam logic [7:0] WMASK_LOOP     = 8'hC7;
  localparam logic [7:0] WMASK_I_COARSE = 8'h0F;
  localparam logic [7:0] WMASK_I_OFS_LO = 8'h83;
  localparam logic [7:0] WMASK_FULL     = 8'hFF;

  // --------------------
  // field positions
  // --------------------
  localparam int BIT_SDIO_BIDIR = 7;  // 00h
  localparam int BIT_LSB_FIRST  = 6;
  localparam int BIT_SW_RESET   = 5;
  localparam int BIT_SLEEP      = 4;
  localparam int BIT_PWR_DOWN   = 3;
  localparam int BIT_ONE_RES    = 2;
  localparam int BIT_LOCK       = 1;
  localparam int BIT_INTERP_LO  = 6;  // 01h, two bits
  localparam int BIT_MOD_LO     = 4;
  localparam int BIT_ZERO_STUFF = 3;
  localparam int BIT_REAL_MIX   = 2;
  localparam int BIT_PLUS_SIDE  = 1;
  localparam int BIT_CLK_ON_PIN = 0;
  localparam int BIT_UNSIGNED   = 7;  // 02h
  localparam int BIT_ONE_PORT   = 6;
  localparam int BIT_CLK_STRONG = 5;
  localparam int BIT_CLK_INVERT = 4;
  localparam int BIT_SPC_INVERT = 2;
  localparam int BIT_SEL_INVERT = 1;
  localparam int BIT_Q_FIRST    = 0;
  localparam int BIT_CLK_ON_SDO = 7;  // 03h
  localparam int BIT_PLL_ON     = 7;  // 04h
  localparam int BIT_CP_MANUAL  = 6;
  localparam int BIT_OFS_DIR    = 7;  // 08h

  // --------------------
  // serial instruction byte layout
  // --------------------
  localparam int INSTR_READ_BIT = 7;
  localparam int INSTR_CNT_LO   = 5;  // two bits, bytes minus one
  localparam logic [2:0] LAST_BIT = 3'h7;

  // interpolation codes, in field order
  typedef enum logic [1:0] {INTERP_BYPASS, INTERP_X2, INTERP_X4, INTERP_X8} dmc_interp_e;

  // serial port phases
  typedef enum logic [1:0] {SP_INSTR, SP_DATA, SP_DONE} dmc_sp_state_e;

  // writable mask of one register
  function automatic logic [7:0] dmc_wmask(input logic [4:0] addr);
    case (addr)
      ADDR_PORT_PWR: dmc_wmask = WMASK_PORT_PWR;
      ADDR_FORMAT:   dmc_wmask = WMASK_FORMAT;
      ADDR_RATE_CLK: dmc_wmask = WMASK_RATE_CLK;
      ADDR_LOOP:     dmc_wmask = WMASK_LOOP;
      ADDR_I_COARSE: dmc_wmask = WMASK_I_COARSE;
      ADDR_I_OFS_LO: dmc_wmask = WMASK_I_OFS_LO;
      default:       dmc_wmask = WMASK_FULL;
    endcase
  endfunction : dmc_wmask

  // reset value of one register
  function automatic logic [7:0] dmc_rst_val(input logic [4:0] addr);
    dmc_rst_val = (addr == ADDR_INTERP) ? RST_INTERP : RST_DEFAULT;
  endfunction : dmc_rst_val

endpackage : dmc_pkg

`default_nettype wire

// [hw/dmc_spi_port.sv]
// serial peripheral port engine: instruction byte, data bytes, readback
`timescale 1ns/1ps
`default_nettype none

module dmc_spi_port (
  // clock and reset
  input  wire logic core_clk_in,
  input  wire logic reset_n_in,
  input  wire logic clk_en_in,
  // serial pins
  input  wire logic csb_in,
  input  wire logic sclk_in,
  input  wire logic sdio_in,
  output logic      sdio_out,
  output logic      sdio_oe_out,
  output logic      sdo_out,
  output logic      sdo_oe_out,
  // register side
  dmc_cfg_if.port   cfg
);
  import dmc_pkg::*;

  // all port state
  typedef struct packed {
    dmc_sp_state_e st;
    logic          sclk_prev;
    logic [2:0]    bit_cnt;
    logic [7:0]    rx;
    logic [7:0]    tx;
    logic          rd;
    logic [1:0]    left;
    logic [4:0]    addr;
    logic          wr_stb;
    logic [4:0]    wr_addr;
    logic [7:0]    wr_data;
    logic          sdio_o;
    logic          sdio_oe;
    logic          sdo_o;
    logic          sdo_oe;
  } dmc_port_s;

  dmc_port_s s_q;  // registered state
  dmc_port_s s_d;  // next state

  logic       rise;  // sclk rising, seen this cycle
  logic       fall;  // sclk falling
  logic [7:0] nxt;   // receive byte with the new bit
  logic [7:0] byte_v;  // byte being shifted out
  logic       bit_v;   // bit presented this edge

  // --------------------
  // next state
  // --------------------
  always_comb begin
    s_d           = s_q;
    s_d.wr_stb    = 1'b0;
    s_d.sclk_prev = sclk_in;
    rise   = sclk_in & ~s_q.sclk_prev;
    fall   = ~sclk_in & s_q.sclk_prev;
    nxt    = cfg.lsb_first ? {sdio_in, s_q.rx[7:1]} : {s_q.rx[6:0], sdio_in};
    byte_v = (s_q.bit_cnt == 3'h0) ? cfg.rd_data : s_q.tx;
    bit_v  = cfg.lsb_first ? byte_v[0] : byte_v[7];
    if (csb_in) begin
      // chip select high restarts the cycle and releases the pins
      s_d.st      = SP_INSTR;
      s_d.bit_cnt = 3'h0;
      s_d.sdio_oe = 1'b0;
      s_d.sdo_oe  = 1'b0;
    end else if (rise && s_q.st != SP_DONE) begin
      // data is sampled on the rising edge
      s_d.rx      = nxt;
      s_d.bit_cnt = s_q.bit_cnt + 3'h1;
      if (s_q.bit_cnt == LAST_BIT) begin
        if (s_q.st == SP_INSTR) begin
          s_d.rd   = nxt[INSTR_READ_BIT];
          s_d.left = nxt[INSTR_CNT_LO+:2];
          s_d.addr = nxt[4:0];
          s_d.st   = SP_DATA;
        end else begin
          s_d.wr_stb  = ~s_q.rd;
          s_d.wr_addr = s_q.addr;
          s_d.wr_data = nxt;
          // msb first walks down the map, lsb first walks up
          s_d.addr = cfg.lsb_first ? s_q.addr + 5'h01 : s_q.addr - 5'h01;
          s_d.left = s_q.left - 2'h1;
          if (s_q.left == 2'h0) begin
            s_d.st = SP_DONE;
          end
        end
      end
    end else if (fall && s_q.st == SP_DATA && s_q.rd) begin
      // read data changes on the falling edge, first bit loads a byte
      s_d.tx = cfg.lsb_first ? {1'b0, byte_v[7:1]} : {byte_v[6:0], 1'b0};
      if (cfg.sdio_bidir) begin
        s_d.sdio_o  = bit_v;
        s_d.sdio_oe = 1'b1;
      end else begin
        s_d.sdo_o  = bit_v;
        s_d.sdo_oe = 1'b1;
      end
    end
  end

  // state register; clock enable freezes everything
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_q <= '0;
    end else if (clk_en_in) begin
      s_q <= s_d;
    end
  end

  assign cfg.wr_stb  = s_q.wr_stb;
  assign cfg.wr_addr = s_q.wr_addr;
  assign cfg.wr_data = s_q.wr_data;
  assign cfg.rd_addr = s_q.addr;
  assign sdio_out    = s_q.sdio_o;
  assign sdio_oe_out = s_q.sdio_oe;
  assign sdo_out     = s_q.sdo_o;
  assign sdo_oe_out  = s_q.sdo_oe;

endmodule : dmc_spi_port

`default_nettype wire
